/* logic/pwr_save_pkg.sv */
// Package of constants and types for the power-saving controller
package pwr_save_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] ADDR_ARM      = 8'h00;
  localparam logic [7:0] ADDR_EDGE     = 8'h04;
  localparam logic [7:0] ADDR_INT_STAT = 8'h08;
  localparam logic [7:0] ADDR_INT_CLR  = 8'h0c;
  localparam logic [7:0] ADDR_INT_EN   = 8'h10;
  localparam logic [7:0] ADDR_STATUS   = 8'h14;

  // Edge polarity register fields
  localparam int EDGE_POL_LSB   = 0;
  localparam int EDGE_POL_W     = 4;
  localparam int EDGE_KEY_BIT   = 4;
  localparam logic [4:0] EDGE_RESET = 5'h00;

  // Interrupt status fields
  localparam int EV_HALT_BIT  = 0;
  localparam int EV_GATE_BIT  = 1;
  localparam int EV_WAKE_BIT  = 2;
  localparam int EV_W         = 3;
  localparam logic [2:0] EV_RESET = 3'h0;

  // Status register fields
  localparam int ST_STATE_LSB  = 0;
  localparam int ST_OSC_BIT    = 4;
  localparam int ST_CPU_BIT    = 5;
  localparam int ST_ARM_BIT    = 6;
  localparam int ST_TIMER_LSB  = 8;

  // Timing
  localparam int CLK_MHZ          = 100;
  localparam int RST_PIN_MIN_US   = 2;
  localparam int RST_PIN_MIN_CYC  = RST_PIN_MIN_US * CLK_MHZ;
  localparam int STARTUP_CYCLES   = 2048;
  localparam logic [7:0] TIMER1_LOAD = 8'hff;
  localparam logic [2:0] TIMER1_DIV_LAST = 3'h7;

  typedef enum logic [2:0] {
    PS_STARTUP,
    PS_RUN,
    PS_HALT_OSC,
    PS_OSC_WAKE,
    PS_CLK_GATE,
    PS_PIN_RESET
  } pwr_state_t;

  // Interrupt requests already accepted by the interrupt controller
  typedef struct packed {
    logic serial;
    logic timer_x;
    logic timer_y;
    logic other;
    logic software_break_instruction;
  } irq_req_t;

  // Peripheral modes that keep running without the oscillator
  typedef struct packed {
    logic serial_ext_clk;
    logic timer_x_event;
    logic timer_y_event;
  } periph_mode_t;

endpackage

/* logic/power_saving_mode_control.sv */
// Power-saving mode controller with arming, wake logic and start-up delay
`timescale 1ns/1ns

// Functional notes
// - Armed halt-oscillator stops oscillator, holds clock high
// - Halt entry loads timer 1 FF, divide eight
// - Event timers and external serial keep running
// - Pin reset low 2 us ends halt
// - After reset release, delay then reset vector
// - Accepted interrupt wakes halt after start-up delay
// - Return continues after halt-oscillator instruction
// - Halt wake only from listed sources
// - Armed clock-gate stops CPU clock only
// - Pin reset ends clock-gate, delay follows
// - Interrupt ends clock-gate with no delay
// - All sources except break wake clock-gate
// - Any reset disarms both instructions
// - Two consecutive arming writes arm; lone disarms
// - Edge polarity bits and key wake enable
// - Start-up delay is 2048 oscillator cycles
module power_saving_mode_control
  import pwr_save_pkg::*;
(
  input  wire logic         I_REF_CLK,
  input  wire logic         I_RST_N,
  input  wire logic         I_WB_CYC,
  input  wire logic         I_WB_STB,
  input  wire logic         I_WB_WE,
  input  wire logic [7:0]   I_WB_ADR,
  input  wire logic [3:0]   I_WB_SEL,
  input  wire logic [31:0]  I_WB_DAT,
  output logic [31:0]       O_WB_DAT,
  output logic              O_WB_ACK,
  input  wire logic         I_RESET_PIN_N,
  input  wire logic [3:0]   I_EDGE_PIN,
  input  wire logic [3:0]   I_EDGE_IRQ_EN,
  input  wire logic         I_KEY_N,
  input  wire irq_req_t     I_IRQ_REQ,
  input  wire periph_mode_t I_PERIPH_MODE,
  input  wire logic         I_HALT_OSC_INSN,
  input  wire logic         I_CLOCK_GATE_INSN,
  output logic              O_CPU_CLK_EN,
  output logic              O_OSC_EN,
  output logic              O_PERIPH_CLK_EN,
  output logic              O_SERIAL_CLK_EN,
  output logic              O_TIMER_X_CLK_EN,
  output logic              O_TIMER_Y_CLK_EN,
  output logic              O_CPU_RESET,
  output logic              O_RESET_VECTOR,
  output logic              O_WAKE_SERVICE,
  output logic [3:0]        O_EDGE_IRQ,
  output logic              O_IRQ
);

  localparam int RST_CNT_W = $clog2(RST_PIN_MIN_CYC + 1);
  localparam logic [RST_CNT_W-1:0] RST_CNT_MAX =
    RST_CNT_W'(RST_PIN_MIN_CYC);

  // Filtered pin level: second and third stage must agree
  function automatic logic filt(input logic s2, input logic s3,
                                input logic cur);
    filt = (s2 == s3) ? s2 : cur;
  endfunction

  pwr_state_t             state_reg;
  logic [2:0]             rpin_sync_reg;
  logic                   rpin_lvl_reg;
  logic [RST_CNT_W-1:0]   rpin_cnt_reg;
  logic                   pin_rst_reg;
  logic [3:0]             e_s1_reg;
  logic [3:0]             e_s2_reg;
  logic [3:0]             e_s3_reg;
  logic [3:0]             e_lvl_reg;
  logic [2:0]             key_sync_reg;
  logic                   key_lvl_reg;
  logic [3:0]             edge_irq_reg;
  logic                   ack_reg;
  logic [31:0]            rdat_reg;
  logic                   arm_reg;
  logic                   prev_arm_wr_reg;
  logic [4:0]             edge_cfg_reg;
  logic [EV_W-1:0]        ev_stat_reg;
  logic [EV_W-1:0]        ev_en_reg;
  logic [7:0]             timer1_reg;
  logic [2:0]             presc_reg;
  logic                   cpu_clk_reg;
  logic                   osc_reg;
  logic                   periph_reg;
  logic                   cpu_rst_reg;
  logic                   rvec_reg;
  logic                   wsrv_reg;

  logic                   access;
  logic                   wr_take;
  logic [3:0]             pol_edge;
  logic                   key_wake;
  logic                   halt_wake;
  logic                   gate_wake;
  logic                   timer_done;
  logic                   enter_halt;
  logic                   enter_gate;
  logic                   rst_release;
  logic [EV_W-1:0]        ev_set;
  logic [EV_W-1:0]        ev_clr;
  logic [3:0]             e_lvl_next;
  logic [3:0]             e_rise;
  logic [3:0]             e_fall;

  // Reset pin synchroniser and low-time qualifier
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rpin_sync_reg <= 3'h7;
      rpin_lvl_reg  <= 1'b1;
    end else begin
      rpin_sync_reg <= {rpin_sync_reg[1:0], I_RESET_PIN_N};
      rpin_lvl_reg  <= filt(rpin_sync_reg[1], rpin_sync_reg[2],
                            rpin_lvl_reg);
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rpin_cnt_reg <= '0;
      pin_rst_reg  <= 1'b0;
    end else if (rpin_lvl_reg) begin
      rpin_cnt_reg <= '0;
      pin_rst_reg  <= 1'b0;
    end else if (rpin_cnt_reg < RST_CNT_MAX - 1'b1) begin
      rpin_cnt_reg <= rpin_cnt_reg + 1'b1;
    end else begin
      pin_rst_reg  <= 1'b1;
    end
  end

  // Edge and key pin synchronisers
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      e_s1_reg     <= 4'h0;
      e_s2_reg     <= 4'h0;
      e_s3_reg     <= 4'h0;
      e_lvl_reg    <= 4'h0;
      key_sync_reg <= 3'h7;
      key_lvl_reg  <= 1'b1;
    end else begin
      e_s1_reg     <= I_EDGE_PIN;
      e_s2_reg     <= e_s1_reg;
      e_s3_reg     <= e_s2_reg;
      e_lvl_reg    <= e_lvl_next;
      key_sync_reg <= {key_sync_reg[1:0], I_KEY_N};
      key_lvl_reg  <= filt(key_sync_reg[1], key_sync_reg[2],
                           key_lvl_reg);
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_edge
      assign e_lvl_next[g] = filt(e_s2_reg[g], e_s3_reg[g], e_lvl_reg[g]);
      assign e_rise[g]     = e_lvl_next[g] & ~e_lvl_reg[g];
      assign e_fall[g]     = ~e_lvl_next[g] & e_lvl_reg[g];
      // Polarity bit high selects the rising edge
      assign pol_edge[g]   = I_EDGE_IRQ_EN[g] &
        (edge_cfg_reg[EDGE_POL_LSB + g] ? e_rise[g] : e_fall[g]);
    end
  endgenerate

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      edge_irq_reg <= 4'h0;
    end else begin
      edge_irq_reg <= pin_rst_reg ? 4'h0 : pol_edge;
    end
  end

  assign key_wake = edge_cfg_reg[EDGE_KEY_BIT] & ~key_lvl_reg;

  // Wake qualification
  assign halt_wake = (|edge_irq_reg) | key_wake |
    (I_IRQ_REQ.serial  & I_PERIPH_MODE.serial_ext_clk) |
    (I_IRQ_REQ.timer_x & I_PERIPH_MODE.timer_x_event) |
    (I_IRQ_REQ.timer_y & I_PERIPH_MODE.timer_y_event);
  assign gate_wake = (|edge_irq_reg) | key_wake | I_IRQ_REQ.serial |
    I_IRQ_REQ.timer_x | I_IRQ_REQ.timer_y | I_IRQ_REQ.other;

  assign enter_halt  = (state_reg == PS_RUN) & I_HALT_OSC_INSN &
                       arm_reg;
  assign enter_gate  = (state_reg == PS_RUN) & I_CLOCK_GATE_INSN &
                       ~I_HALT_OSC_INSN & arm_reg;
  assign rst_release = (state_reg == PS_PIN_RESET) & ~pin_rst_reg;
  assign timer_done  = (presc_reg == 3'h0) & (timer1_reg == 8'h00);

  // Power state sequencing
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg <= PS_STARTUP;
    end else if (pin_rst_reg) begin
      state_reg <= PS_PIN_RESET;
    end else begin
      case (state_reg)
        PS_STARTUP: begin
          if (timer_done) begin
            state_reg <= PS_RUN;
          end
        end
        PS_RUN: begin
          if (enter_halt) begin
            state_reg <= PS_HALT_OSC;
          end else if (enter_gate) begin
            state_reg <= PS_CLK_GATE;
          end
        end
        PS_HALT_OSC: begin
          if (halt_wake) begin
            state_reg <= PS_OSC_WAKE;
          end
        end
        PS_OSC_WAKE: begin
          if (timer_done) begin
            state_reg <= PS_RUN;
          end
        end
        PS_CLK_GATE: begin
          if (gate_wake) begin
            state_reg <= PS_RUN;
          end
        end
        PS_PIN_RESET: begin
          state_reg <= PS_STARTUP;
        end
        default: begin
          state_reg <= PS_STARTUP;
        end
      endcase
    end
  end

  // Timer 1 as start-up delay: 256 counts of a divide-by-eight source
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      timer1_reg <= TIMER1_LOAD;
      presc_reg  <= TIMER1_DIV_LAST;
    end else if (enter_halt | (state_reg == PS_PIN_RESET)) begin
      timer1_reg <= TIMER1_LOAD;
      presc_reg  <= TIMER1_DIV_LAST;
    end else if ((state_reg == PS_STARTUP) |
                 (state_reg == PS_OSC_WAKE)) begin
      if (presc_reg == 3'h0) begin
        presc_reg  <= TIMER1_DIV_LAST;
        timer1_reg <= timer_done ? TIMER1_LOAD : timer1_reg - 1'b1;
      end else begin
        presc_reg  <= presc_reg - 1'b1;
      end
    end
  end

  // Clock, oscillator and CPU control outputs
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cpu_clk_reg <= 1'b0;
      osc_reg     <= 1'b1;
      periph_reg  <= 1'b1;
      cpu_rst_reg <= 1'b1;
      rvec_reg    <= 1'b0;
      wsrv_reg    <= 1'b0;
    end else begin
      cpu_clk_reg <= 1'b0;
      osc_reg     <= 1'b1;
      periph_reg  <= 1'b1;
      cpu_rst_reg <= 1'b0;
      rvec_reg    <= 1'b0;
      wsrv_reg    <= 1'b0;
      if (pin_rst_reg) begin
        cpu_rst_reg <= 1'b1;
      end else begin
        case (state_reg)
          PS_STARTUP: begin
            cpu_rst_reg <= ~timer_done;
            cpu_clk_reg <= timer_done;
            rvec_reg    <= timer_done;
          end
          PS_RUN: begin
            cpu_clk_reg <= ~(enter_halt | enter_gate);
            osc_reg     <= ~enter_halt;
            periph_reg  <= ~enter_halt;
          end
          PS_HALT_OSC: begin
            osc_reg     <= halt_wake;
            periph_reg  <= halt_wake;
          end
          PS_OSC_WAKE: begin
            cpu_clk_reg <= timer_done;
            wsrv_reg    <= timer_done;
          end
          PS_CLK_GATE: begin
            cpu_clk_reg <= gate_wake;
            wsrv_reg    <= gate_wake;
          end
          PS_PIN_RESET: begin
            cpu_rst_reg <= 1'b1;
          end
          default: begin
            cpu_rst_reg <= 1'b1;
          end
        endcase
      end
    end
  end

  // Wishbone slave: ack one cycle after the strobe, write at the ack edge
  assign access  = I_WB_CYC & I_WB_STB;
  assign wr_take = access & ack_reg & I_WB_WE & I_WB_SEL[0];

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h0000_0000;
    end else begin
      ack_reg  <= access & ~ack_reg;
      if (access & ~ack_reg) begin
        case (I_WB_ADR)
          ADDR_ARM:      rdat_reg <= {31'h0, arm_reg};
          ADDR_EDGE:     rdat_reg <= {27'h0, edge_cfg_reg};
          ADDR_INT_STAT: rdat_reg <= {29'h0, ev_stat_reg};
          ADDR_INT_EN:   rdat_reg <= {29'h0, ev_en_reg};
          ADDR_STATUS:   rdat_reg <= {16'h0, timer1_reg, 1'b0, arm_reg,
                                      cpu_clk_reg, osc_reg, 1'b0, state_reg};
          default:       rdat_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Arming: two consecutive writes arm, any other access breaks the pair
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      arm_reg         <= 1'b0;
      prev_arm_wr_reg <= 1'b0;
    end else if (pin_rst_reg) begin
      arm_reg         <= 1'b0;
      prev_arm_wr_reg <= 1'b0;
    end else if (access & ack_reg) begin
      if (wr_take & (I_WB_ADR == ADDR_ARM)) begin
        arm_reg         <= prev_arm_wr_reg;
        prev_arm_wr_reg <= 1'b1;
      end else begin
        prev_arm_wr_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      edge_cfg_reg <= EDGE_RESET;
      ev_en_reg    <= EV_RESET;
    end else if (pin_rst_reg) begin
      edge_cfg_reg <= EDGE_RESET;
      ev_en_reg    <= EV_RESET;
    end else if (wr_take) begin
      if (I_WB_ADR == ADDR_EDGE) begin
        edge_cfg_reg <= I_WB_DAT[4:0];
      end
      if (I_WB_ADR == ADDR_INT_EN) begin
        ev_en_reg <= I_WB_DAT[EV_W-1:0];
      end
    end
  end

  // Sticky events; a set in the clearing cycle wins
  always_comb begin
    ev_set = '0;
    ev_set[EV_HALT_BIT] = enter_halt;
    ev_set[EV_GATE_BIT] = enter_gate;
    ev_set[EV_WAKE_BIT] = wsrv_reg;
    ev_clr = (wr_take & (I_WB_ADR == ADDR_INT_CLR)) ?
             I_WB_DAT[EV_W-1:0] : '0;
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ev_stat_reg <= EV_RESET;
    end else if (pin_rst_reg) begin
      ev_stat_reg <= EV_RESET;
    end else begin
      ev_stat_reg <= (ev_stat_reg & ~ev_clr) | ev_set;
    end
  end

  assign O_WB_ACK         = ack_reg;
  assign O_WB_DAT         = rdat_reg;
  assign O_CPU_CLK_EN     = cpu_clk_reg;
  assign O_OSC_EN         = osc_reg;
  assign O_PERIPH_CLK_EN  = periph_reg;
  // Event-count timers and externally clocked serial keep running
  assign O_SERIAL_CLK_EN  = periph_reg | I_PERIPH_MODE.serial_ext_clk;
  assign O_TIMER_X_CLK_EN = periph_reg | I_PERIPH_MODE.timer_x_event;
  assign O_TIMER_Y_CLK_EN = periph_reg | I_PERIPH_MODE.timer_y_event;
  assign O_CPU_RESET      = cpu_rst_reg;
  assign O_RESET_VECTOR   = rvec_reg;
  assign O_WAKE_SERVICE   = wsrv_reg;
  assign O_EDGE_IRQ       = edge_irq_reg;
  assign O_IRQ            = |(ev_stat_reg & ev_en_reg);

endmodule // power_saving_mode_control

/* bench/pwr_save_checker_assertions.sv */
// Port-level checker for the power-saving controller
`timescale 1ns/1ns
module pwr_save_checker
  import pwr_save_pkg::*;
(
  input wire logic         I_REF_CLK,
  input wire logic         I_RST_N,
  input wire logic         I_WB_CYC,
  input wire logic         I_WB_STB,
  input wire logic         O_WB_ACK,
  input wire logic         I_RESET_PIN_N,
  input wire logic [3:0]   I_EDGE_IRQ_EN,
  input wire logic         I_KEY_N,
  input wire irq_req_t     I_IRQ_REQ,
  input wire periph_mode_t I_PERIPH_MODE,
  input wire logic         I_HALT_OSC_INSN,
  input wire logic         O_CPU_CLK_EN,
  input wire logic         O_OSC_EN,
  input wire logic         O_PERIPH_CLK_EN,
  input wire logic         O_SERIAL_CLK_EN,
  input wire logic         O_TIMER_X_CLK_EN,
  input wire logic         O_TIMER_Y_CLK_EN,
  input wire logic         O_CPU_RESET,
  input wire logic         O_RESET_VECTOR,
  input wire logic         O_WAKE_SERVICE,
  input wire logic [3:0]   O_EDGE_IRQ
);
  logic        gate_reg;
  logic        halted_reg;
  logic [11:0] wake_cnt;
  logic [11:0] boot_cnt;
  logic [7:0]  pin_lo_cnt;

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RST_N);

  // Clock-gate state seen at the ports
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) gate_reg <= 1'b0;
    else if (O_CPU_RESET || O_CPU_CLK_EN) gate_reg <= 1'b0;
    else if ($fell(O_CPU_CLK_EN) && O_OSC_EN) gate_reg <= 1'b1;
  end

  // Halt state and cycles since the oscillator restarted
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) halted_reg <= 1'b0;
    else if (O_CPU_RESET || O_CPU_CLK_EN) halted_reg <= 1'b0;
    else if (!O_OSC_EN) halted_reg <= 1'b1;
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) wake_cnt <= 12'h000;
    else if (!halted_reg) wake_cnt <= 12'h000;
    else if (O_OSC_EN) wake_cnt <= wake_cnt + 12'h001;
  end

  // Cycles the CPU is held in reset after every reset source is gone
  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) boot_cnt <= 12'h000;
    else if (!I_RESET_PIN_N || !O_CPU_RESET) boot_cnt <= 12'h000;
    else boot_cnt <= boot_cnt + 12'h001;
  end

  always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
    if (!I_RST_N) pin_lo_cnt <= 8'h00;
    else if (I_RESET_PIN_N) pin_lo_cnt <= 8'h00;
    else if (pin_lo_cnt != 8'hff) pin_lo_cnt <= pin_lo_cnt + 8'h01;
  end

  a_ack_next: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK
    |=> O_WB_ACK) else $error("bus request not acked next cycle");
  a_ack_pulse: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack longer than one cycle");
  a_halt_stops_cpu: assert property ($fell(O_OSC_EN)
    |-> !O_CPU_CLK_EN && $past(I_HALT_OSC_INSN))
    else $error("oscillator stopped without halt");
  a_periph_follows_osc: assert property (O_PERIPH_CLK_EN == O_OSC_EN)
    else $error("peripheral clock differs from oscillator");
  a_event_clocks_run: assert property (!O_PERIPH_CLK_EN |->
    {O_SERIAL_CLK_EN, O_TIMER_X_CLK_EN, O_TIMER_Y_CLK_EN} == I_PERIPH_MODE)
    else $error("event clocks wrong in halt");
  a_edge_wakes_halt: assert property (!O_OSC_EN &&
    (O_EDGE_IRQ & I_EDGE_IRQ_EN) != 4'h0 |-> ##[0:1] O_OSC_EN)
    else $error("edge did not wake halt");
  a_halt_ignores_other: assert property (!O_OSC_EN && I_KEY_N &&
    I_IRQ_REQ == irq_req_t'(5'h02) && O_EDGE_IRQ == 4'h0 && I_RESET_PIN_N
    |=> !O_OSC_EN) else $error("halt woken by unlisted source");
  a_gate_irq_wake: assert property (gate_reg && !O_CPU_CLK_EN &&
    I_IRQ_REQ[4:1] != 4'h0 |=> O_CPU_CLK_EN && O_WAKE_SERVICE)
    else $error("clock-gate not ended by request");
  a_brk_no_wake: assert property (gate_reg && !O_CPU_CLK_EN && I_KEY_N &&
    I_IRQ_REQ == irq_req_t'(5'h01) && O_EDGE_IRQ == 4'h0 |=> !O_CPU_CLK_EN)
    else $error("break request ended clock-gate");
  a_wake_delay: assert property ($rose(O_CPU_CLK_EN) && halted_reg
    |-> wake_cnt >= 12'h7fe && wake_cnt <= 12'h802 && O_WAKE_SERVICE)
    else $error("halt wake delay wrong");
  a_boot_delay: assert property ($fell(O_CPU_RESET) |->
    (boot_cnt >= 12'h7ff && boot_cnt <= 12'h80a) ##[0:1] O_RESET_VECTOR)
    else $error("start-up delay wrong");
  a_pin_reset_taken: assert property (pin_lo_cnt == 8'hd7
    |-> O_CPU_RESET && O_OSC_EN && !O_CPU_CLK_EN)
    else $error("long pin reset not taken");

  c_gate_wake: cover property (gate_reg && O_WAKE_SERVICE);
  c_halt_wake: cover property ($rose(O_CPU_CLK_EN) && halted_reg);
  c_pin_reset: cover property (pin_lo_cnt == 8'hd7);
endmodule // pwr_save_checker

bind power_saving_mode_control pwr_save_checker pwr_save_checker_inst (
  .I_REF_CLK(I_REF_CLK), .I_RST_N(I_RST_N), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .O_WB_ACK(O_WB_ACK), .I_RESET_PIN_N(I_RESET_PIN_N),
  .I_EDGE_IRQ_EN(I_EDGE_IRQ_EN), .I_KEY_N(I_KEY_N), .I_IRQ_REQ(I_IRQ_REQ),
  .I_PERIPH_MODE(I_PERIPH_MODE), .I_HALT_OSC_INSN(I_HALT_OSC_INSN),
  .O_CPU_CLK_EN(O_CPU_CLK_EN), .O_OSC_EN(O_OSC_EN),
  .O_PERIPH_CLK_EN(O_PERIPH_CLK_EN), .O_SERIAL_CLK_EN(O_SERIAL_CLK_EN),
  .O_TIMER_X_CLK_EN(O_TIMER_X_CLK_EN), .O_TIMER_Y_CLK_EN(O_TIMER_Y_CLK_EN),
  .O_CPU_RESET(O_CPU_RESET), .O_RESET_VECTOR(O_RESET_VECTOR),
  .O_WAKE_SERVICE(O_WAKE_SERVICE), .O_EDGE_IRQ(O_EDGE_IRQ)
);

/* bench/cpu_model.sv */
// Behavioural CPU and wake-source model facing the controller
`timescale 1ns/1ns
module cpu_model
  import pwr_save_pkg::*;
(
  input  wire logic    i_clk,
  output logic         o_reset_pin_n,
  output logic [3:0]   o_edge_pin,
  output logic [3:0]   o_edge_irq_en,
  output logic         o_key_n,
  output irq_req_t     o_irq_req,
  output periph_mode_t o_periph_mode,
  output logic         o_halt_insn,
  output logic         o_gate_insn
);
  initial begin
    o_reset_pin_n = 1'b1;
    o_edge_pin = 4'h0;
    o_edge_irq_en = 4'h0;
    o_key_n = 1'b1;
    o_irq_req = '0;
    o_periph_mode = '0;
    o_halt_insn = 1'b0;
    o_gate_insn = 1'b0;
  end

  // One-cycle instruction pulse, halt or clock-gate
  task automatic exec(input logic halt);
    @(posedge i_clk);
    o_halt_insn <= halt;
    o_gate_insn <= !halt;
    @(posedge i_clk);
    o_halt_insn <= 1'b0;
    o_gate_insn <= 1'b0;
  endtask

  // Accepted request held for n cycles
  task automatic irq(input irq_req_t v, input int n);
    @(posedge i_clk);
    o_irq_req <= v;
    repeat (n) @(posedge i_clk);
    o_irq_req <= '0;
  endtask

  // Reset pin held low for n cycles
  task automatic pin_reset(input int n);
    @(posedge i_clk);
    o_reset_pin_n <= 1'b0;
    repeat (n) @(posedge i_clk);
    o_reset_pin_n <= 1'b1;
  endtask

  // Wake sources prepared before halting
  task automatic set_src(input logic [3:0] pins, input logic key_n,
                         input periph_mode_t m);
    @(posedge i_clk);
    o_edge_pin <= pins;
    o_edge_irq_en <= 4'h1;
    o_key_n <= key_n;
    o_periph_mode <= m;
  endtask
endmodule // cpu_model

/* bench/tb_power_saving_mode_control.sv */
// Self-checking bench for the power-saving controller
`timescale 1ns/1ns
module tb_power_saving_mode_control import pwr_save_pkg::*;;
  logic         clk, rst_n, cyc, stb, we, ack, pin_n, key_n;
  logic [7:0]   adr;
  logic [31:0]  wdat, rdat;
  logic [3:0]   epin, eien, eirq, sel;
  irq_req_t     irq;
  periph_mode_t pmode;
  logic         hins, gins, cpu_en, osc_en, per_en;
  logic [2:0]   ev_en;
  logic         cpu_rst, wsvc, oirq, rvec;
  logic [2:0]   mon;
  int           miscompares;
  int           compares;

  assign mon = {wsvc, osc_en, cpu_en};

  power_saving_mode_control power_saving_mode_control_inst (
    .I_REF_CLK(clk), .I_RST_N(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
    .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat),
    .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_RESET_PIN_N(pin_n),
    .I_EDGE_PIN(epin), .I_EDGE_IRQ_EN(eien), .I_KEY_N(key_n),
    .I_IRQ_REQ(irq), .I_PERIPH_MODE(pmode), .I_HALT_OSC_INSN(hins),
    .I_CLOCK_GATE_INSN(gins), .O_CPU_CLK_EN(cpu_en), .O_OSC_EN(osc_en),
    .O_PERIPH_CLK_EN(per_en), .O_SERIAL_CLK_EN(ev_en[2]),
    .O_TIMER_X_CLK_EN(ev_en[1]), .O_TIMER_Y_CLK_EN(ev_en[0]),
    .O_CPU_RESET(cpu_rst), .O_RESET_VECTOR(rvec), .O_WAKE_SERVICE(wsvc),
    .O_EDGE_IRQ(eirq), .O_IRQ(oirq)
  );

  cpu_model cpu_model_inst (
    .i_clk(clk), .o_reset_pin_n(pin_n), .o_edge_pin(epin),
    .o_edge_irq_en(eien), .o_key_n(key_n), .o_irq_req(irq),
    .o_periph_mode(pmode), .o_halt_insn(hins), .o_gate_insn(gins)
  );

  task automatic final_report();
    if (miscompares == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Classic single Wishbone cycle, waits for ack
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hf, q);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h0, 4'hf, q);
  endtask

  task automatic arm();
    wr(ADDR_ARM, 32'h1);
    wr(ADDR_ARM, 32'h1);
  endtask

  // Cycles until a monitored output goes high
  task automatic wait_bit(input int b, output int c);
    c = 0;
    while (mon[b] !== 1'b1 && c < 3000) begin
      @(negedge clk);
      c++;
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    final_report();
  end

  initial begin
    logic [31:0] q;
    int n;
    logic [7:0] zero_adr [4] = '{ADDR_EDGE, ADDR_INT_STAT, ADDR_INT_EN, 8'h18};
    rst_n = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    sel = 4'h0;
    adr = 8'h00;
    wdat = 32'h0;
    miscompares = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    wait_bit(0, n);
    check("boot delay", n > 2040 && n < 2060, 1'b1);
    check("reset vector", rvec, 1'b1);
    rd(ADDR_STATUS, q);
    check("armed after reset", q[ST_ARM_BIT], 1'b0);
    for (int i = 0; i < 2; i++) begin
      cpu_model_inst.exec(i[0]);
      repeat (3) @(negedge clk);
      check("disarmed insn", {osc_en, cpu_en}, 2'b11);
    end
    foreach (zero_adr[i]) begin
      rd(zero_adr[i], q);
      check("reset value", q, 32'h0);
    end
    wr(8'h18, 32'hff);
    rd(8'h18, q);
    check("unmapped", q, 32'h0);
    wr(ADDR_EDGE, 32'h1f);
    rd(ADDR_EDGE, q);
    check("edge polarity", q, 32'h1f);
    wb(1'b1, ADDR_EDGE, 32'h0, 4'h0, q);
    rd(ADDR_EDGE, q);
    check("sel ignored", q, 32'h1f);
    wr(ADDR_ARM, 32'h1);
    rd(ADDR_STATUS, q);
    check("single write", q[ST_ARM_BIT], 1'b0);
    arm();
    rd(ADDR_STATUS, q);
    check("double write", q[ST_ARM_BIT], 1'b1);
    wr(ADDR_ARM, 32'h1);
    rd(ADDR_STATUS, q);
    check("lone write", q[ST_ARM_BIT], 1'b0);
    arm();
    wr(ADDR_INT_EN, 32'h7);
    cpu_model_inst.exec(1'b0);
    repeat (2) @(negedge clk);
    check("gate clocks", {cpu_en, osc_en, per_en, oirq}, 4'h7);
    cpu_model_inst.irq(irq_req_t'(5'h01), 3);
    @(negedge clk);
    check("break wake", cpu_en, 1'b0);
    for (int i = 1; i < 5; i++) begin
      if (i > 1) cpu_model_inst.exec(1'b0);
      repeat (3) @(negedge clk);
      cpu_model_inst.irq(irq_req_t'(5'h01 << i), 1);
      @(negedge clk);
      check("gate wake", {cpu_en, wsvc}, 2'b11);
    end
    rd(ADDR_INT_STAT, q);
    check("int status", q, 32'h6);
    wr(ADDR_INT_EN, 32'h0);
    @(negedge clk);
    check("irq masked", oirq, 1'b0);
    wr(ADDR_INT_CLR, 32'h7);
    rd(ADDR_INT_STAT, q);
    check("int cleared", q, 32'h0);
    wr(ADDR_EDGE, 32'h1);
    cpu_model_inst.set_src(4'h1, 1'b1, periph_mode_t'(3'h5));
    repeat (10) @(negedge clk);
    cpu_model_inst.exec(1'b1);
    repeat (2) @(negedge clk);
    check("halt clocks", {osc_en, cpu_en, per_en}, 3'h0);
    check("event clocks", ev_en, 3'h5);
    rd(ADDR_STATUS, q);
    check("timer load", q[15:8], TIMER1_LOAD);
    cpu_model_inst.irq(irq_req_t'(5'h02), 3);
    cpu_model_inst.set_src(4'h0, 1'b1, periph_mode_t'(3'h5));
    repeat (10) @(negedge clk);
    check("no wake", osc_en, 1'b0);
    check("no edge", eirq, 4'h0);
    cpu_model_inst.set_src(4'h1, 1'b1, periph_mode_t'(3'h5));
    wait_bit(1, n);
    check("edge wake", n < 12, 1'b1);
    wait_bit(2, n);
    check("wake delay", n > 2040 && n < 2060, 1'b1);
    wr(ADDR_EDGE, 32'h10);
    cpu_model_inst.exec(1'b1);
    cpu_model_inst.set_src(4'h1, 1'b0, periph_mode_t'(3'h5));
    wait_bit(1, n);
    check("key wake", n < 12, 1'b1);
    cpu_model_inst.set_src(4'h1, 1'b1, periph_mode_t'(3'h5));
    wait_bit(2, n);
    cpu_model_inst.exec(1'b1);
    cpu_model_inst.pin_reset(250);
    @(negedge clk);
    check("pin reset", {cpu_rst, osc_en, cpu_en}, 3'h6);
    wait_bit(0, n);
    check("pin boot delay", n > 2040 && n < 2066, 1'b1);
    rd(ADDR_STATUS, q);
    check("armed after pin", q[ST_ARM_BIT], 1'b0);
    cpu_model_inst.pin_reset(100);
    repeat (150) @(negedge clk);
    check("short pin low", cpu_rst, 1'b0);
    final_report();
  end
endmodule // tb_power_saving_mode_control
